// File: verif/ricc_console_model.sv
`timescale 1ns/10ps
`include "ricc_map.svh"
module ricc_console_model
(
    // Clock
    input wire logic i_clk,
    // Controller status
    input wire logic [15:0] i_status,
    // Console pins
    output logic [15:0] o_pins
);
    initial o_pins = 16'h0000;

    // Held for 8 cycles so the input filter always sees it
    task press(input int b);
        @(posedge i_clk);
        o_pins[b] <= 1'b1;
        repeat (8) @(posedge i_clk);
        o_pins[b] <= 1'b0;
        repeat (8) @(posedge i_clk);
    endtask

    task set_prog(input logic [3:0] p);
        @(posedge i_clk);
        o_pins[`RICC_IN_PROG_HI:`RICC_IN_PROG_LO] <= p;
    endtask

    task wait_status(input int b);
        int n;
        n = 0;
        while (i_status[b] !== 1'b1 && n < 100)
        begin
            @(negedge i_clk);
            n++;
        end
    endtask

    task run_prog(input logic [3:0] p);
        set_prog(p);
        wait_status(`RICC_OUT_RESET);
        press(`RICC_IN_START);
    endtask

    task stop_prog;
        press(`RICC_IN_PAUSE);
        wait_status(`RICC_OUT_PAUSED);
        press(`RICC_IN_RESET);
    endtask
endmodule

// File: verif/ricc_core_chk.sv
`timescale 1ns/10ps
module ricc_core_chk
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // Watched ports
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic o_wb_ack,
    input wire ricc_pkg::ricc_fbk_type i_fbk,
    input wire ricc_pkg::ricc_cmd_type o_cmd,
    input wire logic [15:0] o_remote_out
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    property p_ack;
        i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack;
    endproperty
    a_ack: assert property (p_ack) else $error("bus ack not a single pulse");
    property p_launch;
        o_cmd.launch |-> o_remote_out[2] && !o_remote_out[0];
    endproperty
    a_launch: assert property (p_launch) else $error("launch without running");
    property p_paused;
        $rose(o_remote_out[1]) |-> $past(i_fbk.motion_stopped) && o_cmd.hold;
    endproperty
    a_paused: assert property (p_paused) else $error("paused before motion stopped");
    property p_hold;
        o_remote_out[1] |-> o_cmd.hold && !o_remote_out[0];
    endproperty
    a_hold: assert property (p_hold) else $error("paused without hold");
    property p_gate;
        !o_remote_out[15] ##1 !o_remote_out[15] |-> !(o_cmd.launch || o_cmd.go_home || o_cmd.start_cal);
    endproperty
    a_gate: assert property (p_gate) else $error("command while disabled");
    property p_teach;
        o_remote_out[14] |-> !o_remote_out[13] && !o_remote_out[15];
    endproperty
    a_teach: assert property (p_teach) else $error("teach mode enables console");
    property p_err;
        i_fbk.error_evt |-> ##[1:2] o_remote_out[10];
    endproperty
    a_err: assert property (p_err) else $error("error not shown");
    property p_abort;
        o_cmd.abort |-> ##[0:1] (o_remote_out[0] && !o_cmd.hold);
    endproperty
    a_abort: assert property (p_abort) else $error("abort without reset state");
    property p_cal;
        o_cmd.start_cal |-> ##[0:1] o_remote_out[8];
    endproperty
    a_cal: assert property (p_cal) else $error("calibration not shown");
    property p_home;
        o_cmd.go_home |-> ##[0:1] o_remote_out[2];
    endproperty
    a_home: assert property (p_home) else $error("homing not shown running");
endmodule

bind ricc_core ricc_core_chk chk_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb), .o_wb_ack(o_wb_ack), .i_fbk(i_fbk), .o_cmd(o_cmd), .o_remote_out(o_remote_out));

// File: verif/ricc_tb.sv
`timescale 1ns/10ps
`include "ricc_map.svh"
module testbench;
    logic i_clk;
    logic i_nrst;
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic [31:0] q;
    logic ack;
    logic [15:0] pins;
    logic [15:0] outs;
    logic clr;
    ricc_pkg::ricc_fbk_type fbk;
    ricc_pkg::ricc_cmd_type cmd;
    ricc_pkg::ricc_cmd_type seen;
    int bad_count;
    int comparisons;

    ricc_core dut_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(1'b1), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
        .i_remote_in(pins), .o_remote_out(outs), .i_fbk(fbk), .o_cmd(cmd));
    ricc_console_model con_u (.i_clk(i_clk), .i_status(outs), .o_pins(pins));

    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    // Command pulses last one cycle, so they are collected here
    always @(negedge i_clk) seen <= clr ? '0 : (seen | cmd);

    // ****************
    // Shared tasks
    // ****************
    task summarize;
        if (bad_count == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge i_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        @(posedge i_clk iff ack === 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task arm;
        @(posedge i_clk);
        clr <= 1'b1;
        @(posedge i_clk);
        clr <= 1'b0;
    endtask

    task fb(input int b);
        @(posedge i_clk);
        fbk[b] <= 1'b1;
        @(posedge i_clk);
        fbk[b] <= 1'b0;
        repeat (2) @(negedge i_clk);
    endtask

    // ****************
    // Scenarios
    // ****************
    task t_gating;
        logic [2:0] m [3];
        m = '{3'h0, 3'h1, 3'h7};
        for (int i = 0; i < 3; i++)
        begin
            wb(1'b1, `RICC_OFS_CTRL, {29'h0, m[i]}, q);
            arm;
            con_u.press(`RICC_IN_START);
            @(negedge i_clk);
            chk("launch", 16'h0000, {15'h0, seen.launch});
            chk("mode", {1'b0, m[i][2], ~m[i][2], 13'h0001}, outs & 16'hE001);
        end
    endtask

    task t_start;
        wb(1'b1, `RICC_OFS_CTRL, 32'h00000003, q);
        arm;
        con_u.run_prog(4'hA);
        @(negedge i_clk);
        chk("run", 16'h80A4, outs & 16'h80F7);
        chk("launch", 16'h001A, {11'h0, seen.launch, cmd.prog_sel});
        con_u.set_prog(4'h5);
        repeat (8) @(negedge i_clk);
        chk("prog", 16'h00A0, outs & 16'h00F0);
    endtask

    task t_pause;
        @(posedge i_clk);
        fbk.motion_stopped <= 1'b0;
        con_u.press(`RICC_IN_PAUSE);
        @(negedge i_clk);
        chk("pausing", 16'h000C, {12'h0, cmd.hold, outs[2:0]});
        @(posedge i_clk);
        fbk.motion_stopped <= 1'b1;
        con_u.wait_status(`RICC_OUT_PAUSED);
        chk("paused", 16'h000E, {12'h0, cmd.hold, outs[2:0]});
        con_u.press(`RICC_IN_START);
        @(negedge i_clk);
        chk("resume", 16'h0004, {12'h0, cmd.hold, outs[2:0]});
    endtask

    task t_error;
        fb(7);
        chk("err", 16'h0400, outs & 16'h0400);
        arm;
        con_u.stop_prog;
        @(negedge i_clk);
        chk("reset", 16'h0001, outs & 16'h0407);
        chk("abort", 16'h0001, {15'h0, seen.abort});
    endtask

    task t_aux;
        arm;
        con_u.press(`RICC_IN_HOME);
        @(negedge i_clk);
        chk("home", 16'h0003, {14'h0, seen.go_home, outs[2]});
        @(posedge i_clk);
        fbk.at_home <= 1'b1;
        fb(2);
        arm;
        con_u.press(`RICC_IN_CAL);
        @(negedge i_clk);
        chk("cal", 16'h0003, {14'h0, seen.start_cal, outs[8]});
        fb(1);
        chk("idle", 16'h0002, {13'h0, outs[8], outs[3], outs[2]});
        con_u.press(`RICC_IN_MON);
        chk("mon", 16'h0003, {14'h0, cmd.motor_pwr, outs[9]});
        con_u.press(`RICC_IN_MOFF);
        chk("moff", 16'h0000, {14'h0, cmd.motor_pwr, outs[9]});
        @(posedge i_clk);
        fbk.estop <= 1'b1;
        fbk.guard_open <= 1'b1;
        repeat (2) @(negedge i_clk);
    endtask

    task t_regs;
        wb(1'b1, 8'h10, 32'hFFFFFFFF, q);
        wb(1'b0, `RICC_OFS_CTRL, 32'h0, q);
        chk("ctrl", 16'h0003, q[15:0]);
        wb(1'b0, `RICC_OFS_STATUS, 32'h0, q);
        chk("status", 16'hB8A9, q[15:0]);
        wb(1'b0, 8'h10, 32'h0, q);
        chk("unmapped", 16'h0000, q[15:0]);
    endtask

    initial
    begin
        i_nrst = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'h0;
        wdat = 32'h0;
        clr = 1'b0;
        fbk = 8'h10;
        bad_count = 0;
        comparisons = 0;
        repeat (5) @(posedge i_clk);
        i_nrst <= 1'b1;
        @(negedge i_clk);
        chk("after_reset", 16'h2001, outs);
        t_gating;
        t_start;
        t_pause;
        t_error;
        t_aux;
        t_regs;
        summarize;
    end

    initial
    begin
        repeat (20000) @(posedge i_clk);
        bad_count++;
        summarize;
    end
endmodule

// File: verilog/ricc_core.sv
// How it works
// - Inputs: reset,pause,start,home,prog,cal,motor on/off.
// - Outputs map status bits zero to fifteen.
// - Accepted reset clears error, aborts program.
// - Accepted reset enters the reset state.
// - Pause halts program, resumable later.
// - Start begins program or resumes from pause.
// - Home request moves manipulator home.
// - Program number sampled when start accepted from reset, not on resume.
// - Calibrate request launches calibration.
// - Motor-on request switches motor power on.
// - Motor-off request switches motor power off.
// - Console selection and mode gate inputs.
// - Teach mode ignores all remote inputs.
// - Unconfigured remote makes every input invalid.
// - Error shown until accepted reset cancels.
`timescale 1ns/10ps
`include "ricc_map.svh"

module ricc_core
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    // Wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    // Discrete console pins
    input wire logic [15:0] i_remote_in,
    output logic [15:0] o_remote_out,
    // Motion controller side
    input wire ricc_pkg::ricc_fbk_type i_fbk,
    output ricc_pkg::ricc_cmd_type o_cmd
);

    ricc_pkg::ricc_core_state_type q;
    ricc_pkg::ricc_core_state_type d;
    logic [15:0] level;
    logic [15:0] rise;
    logic gate_ok;
    logic idle;
    logic req_reset;
    logic req_pause;
    logic req_start;
    logic req_home;
    logic req_cal;
    logic req_mon;
    logic req_moff;
    logic wb_req;
    logic [31:0] rd_word;

    // ****************************************************************
    // Input synchroniser
    // ****************************************************************
    ricc_sync u_sync
    (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_ce(i_ce),
        .i_pins(i_remote_in),
        .o_level(level)
    );

    // ****************************************************************
    // Request acceptance
    // ****************************************************************
    // One action per rising edge: a held line does not repeat.
    assign rise = level & ~q.prev;
    // Teach mode wins over everything, whatever the console selection.
    assign gate_ok = q.ctrl[`RICC_CTRL_CFG]
        & q.ctrl[`RICC_CTRL_SEL]
        & ~q.ctrl[`RICC_CTRL_TEACH];
    // Start from reset, home, calibrate and motor-on need a settled, idle machine; reset, pause, resume and motor-off do not.
    assign idle = (q.phase == ricc_pkg::RICC_PH_RESET) & ~q.homing & ~q.calibrating;

    assign req_reset = gate_ok & rise[`RICC_IN_RESET];
    assign req_pause = gate_ok & rise[`RICC_IN_PAUSE];
    assign req_start = gate_ok & rise[`RICC_IN_START];
    assign req_home = gate_ok & rise[`RICC_IN_HOME];
    assign req_cal = gate_ok & rise[`RICC_IN_CAL];
    assign req_mon = gate_ok & rise[`RICC_IN_MON];
    assign req_moff = gate_ok & rise[`RICC_IN_MOFF];

    // ****************************************************************
    // Register bus decode
    // ****************************************************************
    assign wb_req = i_wb_cyc & i_wb_stb;

    always_comb
    begin
        rd_word = 32'h0000_0000;
        unique case (i_wb_adr)
            `RICC_OFS_CTRL:
            begin
                rd_word = {29'h0000_0000, q.ctrl};
            end
            `RICC_OFS_STATUS:
            begin
                rd_word = {16'h0000, q.outs};
            end
            `RICC_OFS_PINS:
            begin
                rd_word = {16'h0000, level};
            end
            `RICC_OFS_PHASE:
            begin
                rd_word = {28'h000_0000, q.calibrating, q.homing, q.phase};
            end
            default:
            begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        d = q;
        d.prev = level;
        d.cmd.launch = 1'b0;
        d.cmd.abort = 1'b0;
        d.cmd.go_home = 1'b0;
        d.cmd.start_cal = 1'b0;

        // Bus: ack one cycle after the request; writes land on the ack edge
        d.wb_ack = wb_req & ~q.wb_ack;
        if (wb_req & ~q.wb_ack)
        begin
            d.wb_dat = rd_word;
        end
        if (wb_req & q.wb_ack & i_wb_we & i_wb_sel[0] & (i_wb_adr == `RICC_OFS_CTRL))
        begin
            d.ctrl = i_wb_dat[2:0];
        end

        // Program sequencer
        unique case (q.phase)
            ricc_pkg::RICC_PH_RESET:
            begin
                if (req_start & idle)
                begin
                    d.phase = ricc_pkg::RICC_PH_RUN;
                    d.cmd.launch = 1'b1;
                    d.cmd.prog_sel = level[`RICC_IN_PROG_HI:`RICC_IN_PROG_LO];
                end
            end
            ricc_pkg::RICC_PH_RUN:
            begin
                if (req_pause)
                begin
                    d.phase = ricc_pkg::RICC_PH_PAUSING;
                    d.cmd.hold = 1'b1;
                end
                else if (i_fbk.prog_done)
                begin
                    d.phase = ricc_pkg::RICC_PH_RESET;
                end
            end
            ricc_pkg::RICC_PH_PAUSING:
            begin
                // Paused shows only after the hold has brought motion to rest
                if (i_fbk.motion_stopped)
                begin
                    d.phase = ricc_pkg::RICC_PH_PAUSED;
                end
            end
            ricc_pkg::RICC_PH_PAUSED:
            begin
                if (req_start)
                begin
                    d.phase = ricc_pkg::RICC_PH_RUN;
                    d.cmd.hold = 1'b0;
                end
            end
        endcase

        // Home and calibration run only from the reset state
        if (req_home & idle & ~req_start)
        begin
            d.homing = 1'b1;
            d.cmd.go_home = 1'b1;
        end
        else if (q.homing & i_fbk.home_done)
        begin
            d.homing = 1'b0;
        end
        if (req_cal & idle & ~req_start & ~req_home)
        begin
            d.calibrating = 1'b1;
            d.cmd.start_cal = 1'b1;
        end
        else if (q.calibrating & i_fbk.cal_done)
        begin
            d.calibrating = 1'b0;
        end

        // Motor power: off beats on, and emergency stop forces it off
        if (req_mon & idle)
        begin
            d.cmd.motor_pwr = 1'b1;
        end
        if (req_moff | i_fbk.estop)
        begin
            d.cmd.motor_pwr = 1'b0;
        end

        // Reset request overrides phase, hold, launch, homing and calibration above; it is accepted in any
        // phase so a misbehaving host still gets the program aborted.
        if (req_reset)
        begin
            d.cmd.abort = (q.phase != ricc_pkg::RICC_PH_RESET) | q.homing | q.calibrating;
            d.phase = ricc_pkg::RICC_PH_RESET;
            d.cmd.hold = 1'b0;
            d.cmd.launch = 1'b0;
            d.homing = 1'b0;
            d.calibrating = 1'b0;
            d.error = 1'b0;
        end
        // A new error in the clearing cycle survives the clear
        if (i_fbk.error_evt)
        begin
            d.error = 1'b1;
        end

        // Status outputs follow the next state so they stay one flop deep
        d.outs[`RICC_OUT_RESET] = (d.phase == ricc_pkg::RICC_PH_RESET);
        d.outs[`RICC_OUT_PAUSED] = (d.phase == ricc_pkg::RICC_PH_PAUSED);
        d.outs[`RICC_OUT_RUNNING] = (d.phase != ricc_pkg::RICC_PH_RESET) | d.homing | d.calibrating;
        d.outs[`RICC_OUT_HOME] = i_fbk.at_home;
        d.outs[`RICC_OUT_PROG_HI:`RICC_OUT_PROG_LO] = d.cmd.prog_sel;
        d.outs[`RICC_OUT_CAL] = d.calibrating;
        d.outs[`RICC_OUT_MOTOR] = d.cmd.motor_pwr;
        d.outs[`RICC_OUT_ERROR] = d.error;
        d.outs[`RICC_OUT_ESTOP] = i_fbk.estop;
        d.outs[`RICC_OUT_GUARD] = i_fbk.guard_open;
        d.outs[`RICC_OUT_AUTO] = ~d.ctrl[`RICC_CTRL_TEACH];
        d.outs[`RICC_OUT_TEACH] = d.ctrl[`RICC_CTRL_TEACH];
        d.outs[`RICC_OUT_ENABLE] = d.ctrl[`RICC_CTRL_CFG] & d.ctrl[`RICC_CTRL_SEL] & ~d.ctrl[`RICC_CTRL_TEACH];
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    // Prev resets to all ones, but the filter level resets to zero, so a line already high at reset
    // still shows a rising edge, and so a fresh request, once it has passed the filter.
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            q <= '0;
            q.phase <= ricc_pkg::RICC_PH_RESET;
            q.prev <= 16'hFFFF;
            q.ctrl <= `RICC_CTRL_RST;
            q.outs <= 16'h2001;
        end
        else if (i_ce)
        begin
            q <= d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign o_wb_dat = q.wb_dat;
    assign o_wb_ack = q.wb_ack;
    assign o_remote_out = q.outs;
    assign o_cmd = q.cmd;

endmodule

// File: verilog/ricc_map.svh
`ifndef RICC_MAP_SVH
`define RICC_MAP_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define RICC_OFS_CTRL 8'h00
`define RICC_OFS_STATUS 8'h04
`define RICC_OFS_PINS 8'h08
`define RICC_OFS_PHASE 8'h0C

// ****************************************************************
// Control register fields and reset values
// ****************************************************************
`define RICC_CTRL_CFG 0
`define RICC_CTRL_SEL 1
`define RICC_CTRL_TEACH 2
`define RICC_CTRL_RST 3'h0

// ****************************************************************
// Remote input bit positions
// ****************************************************************
`define RICC_IN_RESET 0
`define RICC_IN_PAUSE 1
`define RICC_IN_START 2
`define RICC_IN_HOME 3
`define RICC_IN_PROG_LO 4
`define RICC_IN_PROG_HI 7
`define RICC_IN_CAL 8
`define RICC_IN_MON 9
`define RICC_IN_MOFF 10

// ****************************************************************
// Remote output bit positions
// ****************************************************************
`define RICC_OUT_RESET 0
`define RICC_OUT_PAUSED 1
`define RICC_OUT_RUNNING 2
`define RICC_OUT_HOME 3
`define RICC_OUT_PROG_LO 4
`define RICC_OUT_PROG_HI 7
`define RICC_OUT_CAL 8
`define RICC_OUT_MOTOR 9
`define RICC_OUT_ERROR 10
`define RICC_OUT_ESTOP 11
`define RICC_OUT_GUARD 12
`define RICC_OUT_AUTO 13
`define RICC_OUT_TEACH 14
`define RICC_OUT_ENABLE 15

`endif

// File: verilog/ricc_pkg.sv
package ricc_pkg;

    // ****************************************************************
    // Operating phase of the program sequencer
    // ****************************************************************
    typedef enum logic [1:0]
    {
        RICC_PH_RESET,
        RICC_PH_RUN,
        RICC_PH_PAUSING,
        RICC_PH_PAUSED
    } ricc_phase_type;

    // ****************************************************************
    // Commands to the motion controller
    // ****************************************************************
    typedef struct packed
    {
        logic launch;
        logic abort;
        logic go_home;
        logic start_cal;
        logic hold;
        logic motor_pwr;
        logic [3:0] prog_sel;
    } ricc_cmd_type;

    // ****************************************************************
    // Motion controller feedback
    // ****************************************************************
    typedef struct packed
    {
        logic error_evt;
        logic estop;
        logic guard_open;
        logic motion_stopped;
        logic at_home;
        logic home_done;
        logic cal_done;
        logic prog_done;
    } ricc_fbk_type;

    // ****************************************************************
    // Input filter state
    // ****************************************************************
    typedef struct packed
    {
        logic [15:0] s1;
        logic [15:0] s2;
        logic [15:0] s3;
        logic [15:0] lvl;
    } ricc_sync_state_type;

    // ****************************************************************
    // Console core state
    // ****************************************************************
    typedef struct packed
    {
        ricc_phase_type phase;
        logic homing;
        logic calibrating;
        logic error;
        logic [15:0] prev;
        logic [2:0] ctrl;
        ricc_cmd_type cmd;
        logic [15:0] outs;
        logic wb_ack;
        logic [31:0] wb_dat;
    } ricc_core_state_type;

endpackage

// File: verilog/ricc_sync.sv
`timescale 1ns/10ps

module ricc_sync
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    // Raw pins
    input wire logic [15:0] i_pins,
    // Filtered levels
    output logic [15:0] o_level
);

    ricc_pkg::ricc_sync_state_type q;
    ricc_pkg::ricc_sync_state_type d;
    logic [15:0] lvl_d;

    // ****************************************************************
    // Per-pin level filter
    // ****************************************************************
    // A level counts only once the second and third stages agree, so a
    // metastable first stage never reaches the level.
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1)
        begin : g_pin
            assign lvl_d[gi] = (q.s2[gi] == q.s3[gi]) ? q.s3[gi] : q.lvl[gi];
        end
    endgenerate

    always_comb
    begin
        d = q;
        d.s1 = i_pins;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.lvl = lvl_d;
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            q <= '0;
        end
        else if (i_ce)
        begin
            q <= d;
        end
    end

    assign o_level = q.lvl;

endmodule
